// file: hw/hms_pkg.sv
package hms_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus geometry
   localparam int HMS_ADDR_W = 3;
   localparam int HMS_DATA_W = 8;

   typedef logic [HMS_ADDR_W-1:0] hms_addr_t;
   typedef logic [HMS_DATA_W-1:0] hms_data_t;

   // register addresses on the parallel bus
   localparam hms_addr_t HMS_ADDR_INT_ENABLE = 3'h1;
   localparam hms_addr_t HMS_ADDR_HS_CONTROL = 3'h4;
   localparam hms_addr_t HMS_ADDR_LINE_STATUS = 3'h5;
   localparam hms_addr_t HMS_ADDR_HS_STATUS = 3'h6;

   ////////////////////////////////////////////////////////////////////////////
   // handshake_control fields
   localparam int HMS_CTL_TERM_READY = 0;
   localparam int HMS_CTL_REQ_SEND = 1;
   localparam int HMS_CTL_AUX1 = 2;
   localparam int HMS_CTL_AUX2 = 3;
   localparam int HMS_CTL_LOOPBACK = 4;
   localparam int HMS_CTL_W = 5;
   localparam logic [HMS_CTL_W-1:0] HMS_CTL_RST = 5'h00;
   localparam logic [HMS_DATA_W-HMS_CTL_W-1:0] HMS_CTL_PAD = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // internal handshake vector, also the order of status bits 0..3 and 4..7
   localparam int HMS_HS_CLEAR_SEND = 0;
   localparam int HMS_HS_SET_READY = 1;
   localparam int HMS_HS_RING = 2;
   localparam int HMS_HS_LINE_DETECT = 3;
   localparam int HMS_HS_W = 4;
   localparam logic [HMS_HS_W-1:0] HMS_HS_RST = 4'h0;

   // synchroniser lanes: four handshake pins plus the serial input
   localparam int HMS_SYNC_RX = 4;
   localparam int HMS_SYNC_W = 5;
   localparam logic [HMS_SYNC_W-1:0] HMS_SYNC_IDLE = 5'h1f;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt enable fields
   localparam int HMS_IE_RX_DATA = 0;
   localparam int HMS_IE_TX_EMPTY = 1;
   localparam int HMS_IE_LINE_STATUS = 2;
   localparam int HMS_IE_MODEM = 3;
   localparam int HMS_IE_W = 4;
   localparam logic [HMS_IE_W-1:0] HMS_IE_RST = 4'h0;
   localparam logic [HMS_DATA_W-HMS_IE_W-1:0] HMS_IE_PAD = 4'h0;

   // line status test write width
   localparam int HMS_LS_TEST_W = 6;
   localparam logic [HMS_LS_TEST_W-1:0] HMS_LS_TEST_RST = 6'h00;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt identification codes
   localparam int HMS_IID_W = 3;
   typedef enum logic [HMS_IID_W-1:0] {
      HMS_IID_NONE = 3'b001,
      HMS_IID_LINE_STATUS = 3'b110,
      HMS_IID_RX_DATA = 3'b100,
      HMS_IID_TX_EMPTY = 3'b010,
      HMS_IID_MODEM = 3'b000
   } hms_iid_t;

   localparam hms_data_t HMS_DATA_RST = 8'h00;

endpackage

// file: hw/hms_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; output moves only when stages two and three agree
module hms_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] IDLE = '0
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_lane
         always_comb begin
            q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= IDLE;
         s2_r <= IDLE;
         s3_r <= IDLE;
         q_r <= IDLE;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= q_nxt;
      end
   end

   assign q = q_r;

endmodule // hms_sync

// file: hw/hms_top.sv
`timescale 1ns/1ps
// Functional notes
// - control bit 0 set drives terminal-ready pin low, clear drives it high.
// - control bit 1 drives request-to-send pin, inverted.
// - control bit 2 drives first auxiliary pin, inverted.
// - control bit 3 drives second auxiliary pin, inverted.
// - loopback holds serial output high, ignores rx pin, wraps tx into rx.
// - loopback ignores handshake input pins, feeds control bits to internal inputs; output pins still follow control bits.
// - loopback keeps rx/tx interrupts; modem interrupt comes from control bits, still enabled.
// - cpu writes to line status low six and status low four raise interrupts.
// - control bits 5 to 7 always read zero.
// - change bits set on their condition, cleared by a status read.
// - status bits 0,1,3 flag a change of clear-send, set-ready, line-detect.
// - status bit 2 sets only on ring going from on to off.
// - any of status bits 0 to 3 set requests modem interrupt.
// - status bits 4 to 7 are complements of the four handshake pins.
// - in loopback status bits 4 to 7 mirror rts, dtr, aux1, aux2.
// - modem interrupt reaches output only with enable bit 3 set.
// - modem interrupt has lowest of four priorities.
module hms_top (
   input wire logic clk,
   input wire logic arst_n,
   // parallel register bus, synchronous to clk
   input wire logic bus_cs,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire hms_pkg::hms_addr_t bus_addr,
   input wire hms_pkg::hms_data_t bus_data_in,
   output hms_pkg::hms_data_t bus_data_out,
   output logic bus_data_oe_n,
   // handshake pins, all active low
   output logic terminal_ready_n,
   output logic request_send_n,
   output logic aux1_n,
   output logic aux2_n,
   input wire logic clear_send_in_n,
   input wire logic set_ready_in_n,
   input wire logic ring_in_n,
   input wire logic line_signal_detect_in_n,
   // serial pins and the shift-register side
   input wire logic serial_rx_pin,
   output logic serial_tx_pin,
   input wire logic tx_shift_out,
   output logic rx_shift_in,
   output logic loopback,
   // interrupt sources of higher priority, line status test write outputs and interrupt outputs
   input wire logic line_status_req,
   input wire logic rx_data_req,
   input wire logic tx_empty_req,
   output logic line_status_test_wr,
   output logic [hms_pkg::HMS_LS_TEST_W-1:0] line_status_test_data,
   output logic irq_out,
   output hms_pkg::hms_iid_t irq_id
);
   import hms_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [HMS_SYNC_W-1:0] pins_raw;
   logic [HMS_SYNC_W-1:0] pins_sync;

   always_comb begin
      pins_raw = HMS_SYNC_IDLE;
      pins_raw[HMS_HS_CLEAR_SEND] = clear_send_in_n;
      pins_raw[HMS_HS_SET_READY] = set_ready_in_n;
      pins_raw[HMS_HS_RING] = ring_in_n;
      pins_raw[HMS_HS_LINE_DETECT] = line_signal_detect_in_n;
      pins_raw[HMS_SYNC_RX] = serial_rx_pin;
   end

   // edge detection below only sees the settled copy
   hms_sync #(
      .W(HMS_SYNC_W),
      .IDLE(HMS_SYNC_IDLE)
   ) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d(pins_raw),
      .q(pins_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic wr_ie;
   logic wr_ctl;
   logic wr_ls;
   logic wr_sts;
   logic rd_ie;
   logic rd_ctl;
   logic rd_sts;
   logic rd_any;

   always_comb begin
      wr_ie = bus_cs && bus_wr && (bus_addr == HMS_ADDR_INT_ENABLE);
      wr_ctl = bus_cs && bus_wr && (bus_addr == HMS_ADDR_HS_CONTROL);
      wr_ls = bus_cs && bus_wr && (bus_addr == HMS_ADDR_LINE_STATUS);
      wr_sts = bus_cs && bus_wr && (bus_addr == HMS_ADDR_HS_STATUS);
      rd_ie = bus_cs && bus_rd && (bus_addr == HMS_ADDR_INT_ENABLE);
      rd_ctl = bus_cs && bus_rd && (bus_addr == HMS_ADDR_HS_CONTROL);
      rd_sts = bus_cs && bus_rd && (bus_addr == HMS_ADDR_HS_STATUS);
      rd_any = rd_ie || rd_ctl || rd_sts;
   end

   ////////////////////////////////////////////////////////////////////////////
   // control and enable registers

   logic [HMS_CTL_W-1:0] ctl_r;
   logic [HMS_CTL_W-1:0] ctl_nxt;
   logic [HMS_IE_W-1:0] ie_r;
   logic [HMS_IE_W-1:0] ie_nxt;
   logic ls_wr_r;
   logic ls_wr_nxt;
   logic [HMS_LS_TEST_W-1:0] ls_data_r;
   logic [HMS_LS_TEST_W-1:0] ls_data_nxt;

   always_comb begin
      ctl_nxt = ctl_r;
      ie_nxt = ie_r;
      ls_data_r_hold: begin
         ls_data_nxt = ls_data_r;
      end
      ls_wr_nxt = wr_ls;
      if (wr_ctl) begin
         // bits above the loopback bit are not stored
         ctl_nxt = bus_data_in[HMS_CTL_W-1:0];
      end
      if (wr_ie) begin
         ie_nxt = bus_data_in[HMS_IE_W-1:0];
      end
      if (wr_ls) begin
         // line status lives in the receiver; pass the test pattern on
         ls_data_nxt = bus_data_in[HMS_LS_TEST_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_r <= HMS_CTL_RST;
         ie_r <= HMS_IE_RST;
         ls_wr_r <= 1'b0;
         ls_data_r <= HMS_LS_TEST_RST;
      end else begin
         ctl_r <= ctl_nxt;
         ie_r <= ie_nxt;
         ls_wr_r <= ls_wr_nxt;
         ls_data_r <= ls_data_nxt;
      end
   end

   logic loop;
   assign loop = ctl_r[HMS_CTL_LOOPBACK];

   ////////////////////////////////////////////////////////////////////////////
   // pin drivers and serial path

   logic dtr_n_r;
   logic rts_n_r;
   logic aux1_n_r;
   logic aux2_n_r;
   logic tx_pin_r;
   logic rx_in_r;
   logic loop_r;
   logic dtr_n_nxt;
   logic rts_n_nxt;
   logic aux1_n_nxt;
   logic aux2_n_nxt;
   logic tx_pin_nxt;
   logic rx_in_nxt;

   always_comb begin
      dtr_n_nxt = !ctl_nxt[HMS_CTL_TERM_READY];
      rts_n_nxt = !ctl_nxt[HMS_CTL_REQ_SEND];
      aux1_n_nxt = !ctl_nxt[HMS_CTL_AUX1];
      aux2_n_nxt = !ctl_nxt[HMS_CTL_AUX2];
      // loopback parks the line at mark and wraps the shifter
      tx_pin_nxt = loop ? 1'b1 : tx_shift_out;
      rx_in_nxt = loop ? tx_shift_out : pins_sync[HMS_SYNC_RX];
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dtr_n_r <= 1'b1;
         rts_n_r <= 1'b1;
         aux1_n_r <= 1'b1;
         aux2_n_r <= 1'b1;
         tx_pin_r <= 1'b1;
         rx_in_r <= 1'b1;
         loop_r <= 1'b0;
      end else begin
         dtr_n_r <= dtr_n_nxt;
         rts_n_r <= rts_n_nxt;
         aux1_n_r <= aux1_n_nxt;
         aux2_n_r <= aux2_n_nxt;
         tx_pin_r <= tx_pin_nxt;
         rx_in_r <= rx_in_nxt;
         loop_r <= ctl_nxt[HMS_CTL_LOOPBACK];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // internal handshake inputs, active high

   logic [HMS_HS_W-1:0] hs_now;

   always_comb begin
      if (loop) begin
         // pins are ignored; control bits take their place
         hs_now[HMS_HS_CLEAR_SEND] = ctl_r[HMS_CTL_REQ_SEND];
         hs_now[HMS_HS_SET_READY] = ctl_r[HMS_CTL_TERM_READY];
         hs_now[HMS_HS_RING] = ctl_r[HMS_CTL_AUX1];
         hs_now[HMS_HS_LINE_DETECT] = ctl_r[HMS_CTL_AUX2];
      end else begin
         hs_now = ~pins_sync[HMS_HS_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // change detection

   logic [HMS_HS_W-1:0] hs_prev_r;
   logic [HMS_HS_W-1:0] delta_r;
   logic [HMS_HS_W-1:0] delta_nxt;
   logic [HMS_HS_W-1:0] delta_set;

   always_comb begin
      delta_set = hs_now ^ hs_prev_r;
      // ring flags only its trailing edge
      delta_set[HMS_HS_RING] = hs_prev_r[HMS_HS_RING] && !hs_now[HMS_HS_RING];
      delta_nxt = delta_r;
      if (rd_sts) begin
         delta_nxt = HMS_HS_RST;
      end
      if (wr_sts) begin
         // test write: ones raise the flag as a real change would
         delta_nxt = bus_data_in[HMS_HS_W-1:0];
      end
      // a change in the clearing cycle is kept
      delta_nxt = delta_nxt | delta_set;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hs_prev_r <= HMS_HS_RST;
         delta_r <= HMS_HS_RST;
      end else begin
         hs_prev_r <= hs_now;
         delta_r <= delta_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data

   hms_data_t rdata_r;
   hms_data_t rdata_nxt;
   logic oe_n_r;
   logic oe_n_nxt;

   always_comb begin
      rdata_nxt = rdata_r;
      oe_n_nxt = !rd_any;
      if (rd_ctl) begin
         rdata_nxt = {HMS_CTL_PAD, ctl_r};
      end else if (rd_ie) begin
         rdata_nxt = {HMS_IE_PAD, ie_r};
      end else if (rd_sts) begin
         // value before the clear of this read
         rdata_nxt = {hs_now, delta_r};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= HMS_DATA_RST;
         oe_n_r <= 1'b1;
      end else begin
         rdata_r <= rdata_nxt;
         oe_n_r <= oe_n_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt priority

   logic modem_req;
   logic irq_r;
   logic irq_nxt;
   hms_iid_t iid_r;
   hms_iid_t iid_nxt;

   assign modem_req = |delta_r;

   // rx and tx sources are not touched by loopback
   always_comb begin
      irq_nxt = 1'b1;
      if (line_status_req && ie_r[HMS_IE_LINE_STATUS]) begin
         iid_nxt = HMS_IID_LINE_STATUS;
      end else if (rx_data_req && ie_r[HMS_IE_RX_DATA]) begin
         iid_nxt = HMS_IID_RX_DATA;
      end else if (tx_empty_req && ie_r[HMS_IE_TX_EMPTY]) begin
         iid_nxt = HMS_IID_TX_EMPTY;
      end else if (modem_req && ie_r[HMS_IE_MODEM]) begin
         iid_nxt = HMS_IID_MODEM;
      end else begin
         iid_nxt = HMS_IID_NONE;
         irq_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_r <= 1'b0;
         iid_r <= HMS_IID_NONE;
      end else begin
         irq_r <= irq_nxt;
         iid_r <= iid_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign bus_data_out = rdata_r;
   assign bus_data_oe_n = oe_n_r;
   assign terminal_ready_n = dtr_n_r;
   assign request_send_n = rts_n_r;
   assign aux1_n = aux1_n_r;
   assign aux2_n = aux2_n_r;
   assign serial_tx_pin = tx_pin_r;
   assign rx_shift_in = rx_in_r;
   assign loopback = loop_r;
   assign line_status_test_wr = ls_wr_r;
   assign line_status_test_data = ls_data_r;
   assign irq_out = irq_r;
   assign irq_id = iid_r;

endmodule // hms_top

// file: test/hms_checker.sv
`timescale 1ns/1ps
module hms_checker
   import hms_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic bus_cs,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire hms_pkg::hms_addr_t bus_addr,
   input wire hms_pkg::hms_data_t bus_data_in,
   input wire hms_pkg::hms_data_t bus_data_out,
   input wire logic bus_data_oe_n,
   input wire logic terminal_ready_n,
   input wire logic request_send_n,
   input wire logic aux1_n,
   input wire logic aux2_n,
   input wire logic serial_tx_pin,
   input wire logic tx_shift_out,
   input wire logic rx_shift_in,
   input wire logic loopback,
   input wire logic line_status_req,
   input wire logic irq_out,
   input wire hms_pkg::hms_iid_t irq_id
);
   import hms_pkg::*;
   // shadow of the enable register, seen only through bus writes
   logic [3:0] ie_r;
   logic wctl, rd_ctl, rd_st;
   assign wctl = bus_cs && bus_wr && bus_addr == HMS_ADDR_HS_CONTROL;
   assign rd_ctl = bus_cs && bus_rd && bus_addr == HMS_ADDR_HS_CONTROL;
   assign rd_st = bus_cs && bus_rd && bus_addr == HMS_ADDR_HS_STATUS;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ie_r <= 4'h0;
      end else if (bus_cs && bus_wr && bus_addr == HMS_ADDR_INT_ENABLE) begin
         ie_r <= bus_data_in[3:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////
   property p_ctl_pins;
      wctl |=> {aux2_n, aux1_n, request_send_n, terminal_ready_n} == ~$past(bus_data_in[3:0]);
   endproperty
   a_ctl_pins: assert property (p_ctl_pins) else $error("pins miss control write");
   property p_tx_idle;
      loopback && $past(loopback) |-> serial_tx_pin;
   endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("tx pin low in loopback");
   property p_wrap;
      loopback && $past(loopback) |-> rx_shift_in == $past(tx_shift_out);
   endproperty
   a_wrap: assert property (p_wrap) else $error("tx not wrapped to rx");
   property p_ctl_pad;
      rd_ctl |=> !bus_data_oe_n && bus_data_out[7:5] == 3'h0;
   endproperty
   a_ctl_pad: assert property (p_ctl_pad) else $error("control upper bits not zero");
   property p_lb_status;
      rd_st && loopback && $past(loopback) |=>
         bus_data_out[7:4] == ~{aux2_n, aux1_n, terminal_ready_n, request_send_n};
   endproperty
   a_lb_status: assert property (p_lb_status) else $error("loopback status wrong");
   property p_ls_id;
      irq_id == HMS_IID_LINE_STATUS |-> $past(line_status_req);
   endproperty
   a_ls_id: assert property (p_ls_id) else $error("line status id without request");
   property p_modem_gate;
      irq_id == HMS_IID_MODEM |-> irq_out && $past(ie_r[3]);
   endproperty
   a_modem_gate: assert property (p_modem_gate) else $error("modem irq not enabled");
   property p_st_wr;
      bus_cs && bus_wr && bus_addr == HMS_ADDR_HS_STATUS && bus_data_in[3:0] != 4'h0 && ie_r[3]
         |=> ##1 irq_out;
   endproperty
   a_st_wr: assert property (p_st_wr) else $error("status write no irq");
endmodule // hms_checker

bind hms_top hms_checker hms_checker_inst (.clk, .arst_n, .bus_cs, .bus_rd, .bus_wr, .bus_addr,
   .bus_data_in, .bus_data_out, .bus_data_oe_n, .terminal_ready_n, .request_send_n, .aux1_n, .aux2_n,
   .serial_tx_pin, .tx_shift_out, .rx_shift_in, .loopback, .line_status_req, .irq_out, .irq_id);

// file: test/hms_modem.sv
`timescale 1ns/1ps
// far-side data set; lines change one clock after the request, never mid-cycle
module hms_modem (
   input wire logic clk,
   input wire logic [3:0] lvl,
   output logic clear_send_in_n,
   output logic set_ready_in_n,
   output logic ring_in_n,
   output logic line_signal_detect_in_n
);
   logic [3:0] pin_r = 4'hf;
   always @(posedge clk) begin
      pin_r <= ~lvl;
   end
   assign {line_signal_detect_in_n, ring_in_n, set_ready_in_n, clear_send_in_n} = pin_r;
endmodule // hms_modem

// file: test/hms_top_bench.sv
`timescale 1ns/1ps
module hms_top_bench;
   import hms_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, bus_cs = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0;
   hms_addr_t bus_addr = 3'h0;
   hms_data_t bus_data_in = 8'h00, bus_data_out;
   logic bus_data_oe_n, terminal_ready_n, request_send_n, aux1_n, aux2_n, serial_tx_pin, rx_shift_in;
   logic clear_send_in_n, set_ready_in_n, ring_in_n, line_signal_detect_in_n, loopback;
   logic serial_rx_pin = 1'b1, tx_shift_out = 1'b1, line_status_test_wr, irq_out;
   logic line_status_req = 1'b0, rx_data_req = 1'b0, tx_empty_req = 1'b0;
   logic [5:0] line_status_test_data;
   hms_iid_t irq_id;
   logic [3:0] lv = 4'h0, flg = 4'h0, ie = 4'h0;
   logic [7:0] ctl = 8'h00;
   logic [31:0] seed = 32'h811f;
   int fails = 0, total_checks = 0;
   hms_top hms_top_inst (.clk, .arst_n, .bus_cs, .bus_rd, .bus_wr, .bus_addr, .bus_data_in, .bus_data_out,
      .bus_data_oe_n, .terminal_ready_n, .request_send_n, .aux1_n, .aux2_n, .clear_send_in_n, .set_ready_in_n,
      .ring_in_n, .line_signal_detect_in_n, .serial_rx_pin, .serial_tx_pin, .tx_shift_out, .rx_shift_in,
      .loopback, .line_status_req, .rx_data_req, .tx_empty_req, .line_status_test_wr, .line_status_test_data,
      .irq_out, .irq_id);
   hms_modem hms_modem_inst (.clk, .lvl(lv), .clear_send_in_n, .set_ready_in_n, .ring_in_n,
      .line_signal_detect_in_n);
   initial begin
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // loopback takes the status level from control bits, else from the modem lines
   function automatic logic [3:0] act();
      return ctl[4] ? {ctl[3], ctl[2], ctl[0], ctl[1]} : lv;
   endfunction
   task tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task wr(input hms_addr_t a, input hms_data_t d);
      @(posedge clk);
      bus_cs <= 1'b1;
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_data_in <= d;
      @(posedge clk);
      bus_cs <= 1'b0;
      bus_wr <= 1'b0;
      #1;
   endtask
   task rd(input hms_addr_t a, output hms_data_t d);
      @(posedge clk);
      bus_cs <= 1'b1;
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_cs <= 1'b0;
      bus_rd <= 1'b0;
      #1;
      d = bus_data_out;
      chk(bus_data_oe_n, !(a inside {HMS_ADDR_INT_ENABLE, HMS_ADDR_HS_CONTROL, HMS_ADDR_HS_STATUS}));
   endtask
   task st();
      hms_data_t d;
      chk(irq_out, flg != 4'h0 && ie[3]);
      rd(HMS_ADDR_HS_STATUS, d);
      chk(d, {act(), flg});
      flg = 4'h0;
      repeat (2) @(posedge clk);
      #1;
      chk(irq_out, 1'b0);
   endtask
   // a ring flag only on on-to-off; lines are ignored in loopback
   task pin(input int i, input logic v);
      if (!ctl[4] && lv[i] != v) flg[i] = (i == 2) ? lv[i] && !v : 1'b1;
      @(posedge clk);
      lv[i] <= v;
      repeat (8) @(posedge clk);
      #1;
   endtask
   initial begin
      repeat (50000) @(posedge clk);
      fails++;
      $display("Error at %0t: run hung", $time);
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      hms_data_t d;
      logic p;
      hms_iid_t ids[4];
      ids = '{HMS_IID_LINE_STATUS, HMS_IID_RX_DATA, HMS_IID_TX_EMPTY, HMS_IID_MODEM};
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk({aux2_n, aux1_n, request_send_n, terminal_ready_n, serial_tx_pin, loopback}, 8'h3e);
      chk(irq_id, HMS_IID_NONE);
      st();
      $display("reset test done");
      for (int k = 0; k < 12; k++) begin
         seed = lfsr(seed);
         ctl = seed[7:0] & 8'hef;
         wr(HMS_ADDR_HS_CONTROL, seed[7:0] & 8'hef);
         ctl = ctl & 8'h1f;
         chk({aux2_n, aux1_n, request_send_n, terminal_ready_n}, {4'h0, ~ctl[3:0]});
         rd(HMS_ADDR_HS_CONTROL, d);
         chk(d, ctl);
      end
      $display("control test done");
      ie = 4'h8;
      wr(HMS_ADDR_INT_ENABLE, 8'hf8);
      for (int i = 0; i < 4; i++) begin
         pin(i, 1'b1);
         st();
         pin(i, 1'b0);
         st();
         st();
      end
      ie = 4'h0;
      wr(HMS_ADDR_INT_ENABLE, 8'h00);
      pin(0, 1'b1);
      st();
      // line-detect flag lands on the very edge that takes the status read
      @(posedge clk);
      lv[3] <= 1'b1;
      repeat (4) @(posedge clk);
      rd(HMS_ADDR_HS_STATUS, d);
      chk(d, {lv, 4'h0});
      flg = 4'h8;
      repeat (2) @(posedge clk);
      st();
      $display("status test done");
      ie = 4'hf;
      wr(HMS_ADDR_INT_ENABLE, 8'hff);
      rd(HMS_ADDR_INT_ENABLE, d);
      chk(d, 8'h0f);
      rd(3'h7, d);
      rd(HMS_ADDR_LINE_STATUS, d);
      wr(HMS_ADDR_HS_STATUS, 8'h05);
      flg = 4'h5;
      chk({line_status_test_wr}, 8'h00);
      wr(HMS_ADDR_LINE_STATUS, 8'hea);
      chk({line_status_test_wr, line_status_test_data}, 8'h6a);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         {line_status_req, rx_data_req, tx_empty_req} <= 3'b111 >> k;
         repeat (3) @(posedge clk);
         #1;
         chk(irq_id, ids[k]);
      end
      st();
      $display("interrupt test done");
      ctl = 8'h15;
      wr(HMS_ADDR_HS_CONTROL, 8'h15);
      repeat (8) @(posedge clk);
      #1;
      chk(loopback, 1'b1);
      rd(HMS_ADDR_HS_STATUS, d);
      flg = 4'h0;
      for (int k = 0; k < 10; k++) begin
         @(posedge clk);
         seed = lfsr(seed);
         tx_shift_out <= seed[0];
         serial_rx_pin <= ~seed[0];
         #1;
         if (k > 0) chk(rx_shift_in, p);
         chk(serial_tx_pin, 1'b1);
         p = seed[0];
      end
      pin(1, 1'b1);
      st();
      // rts rises inside the loop, so clear-to-send changes
      ctl = 8'h17;
      wr(HMS_ADDR_HS_CONTROL, 8'h17);
      flg = 4'h1;
      repeat (8) @(posedge clk);
      st();
      // drop outputs first, then leave loopback
      ctl = 8'h10;
      wr(HMS_ADDR_HS_CONTROL, 8'h10);
      ctl = 8'h00;
      wr(HMS_ADDR_HS_CONTROL, 8'h00);
      chk(loopback, 1'b0);
      repeat (8) @(posedge clk);
      rd(HMS_ADDR_HS_STATUS, d);
      flg = 4'h0;
      repeat (2) @(posedge clk);
      st();
      // out of loopback the pins carry the shifter again; rx pays the sync latency
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         seed = lfsr(seed);
         tx_shift_out <= seed[0];
         serial_rx_pin <= seed[1];
         repeat (6) @(posedge clk);
         #1;
         chk(serial_tx_pin, seed[0]);
         chk(rx_shift_in, seed[1]);
      end
      $display("loopback test done");
      tally_and_finish();
   end
endmodule // hms_top_bench
